// ===== common/dacpm_pkg.sv
`default_nettype none

package dacpm_pkg;

    // ----------------------------------------
    // Widths
    // ----------------------------------------
    localparam int BUS_W     = 16;
    localparam int BUF_DEPTH = 2;
    localparam int SHIFT_W   = 8;
    localparam int SYNC_W    = 6 + 2 * BUS_W;

    // ----------------------------------------
    // Serial frame layout
    // ----------------------------------------
    localparam logic [2:0] LAST_BIT    = 3'h7;
    localparam int         RW_BIT      = 7;
    localparam logic       CMD_READ    = 1'b1;
    localparam logic [4:0] MODE_ADDR   = 5'h00;
    localparam int         MODE_BIT    = 7;
    localparam logic [7:0] READ_ZERO   = 8'h00;

    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam logic THREE_WIRE_RST = 1'b0;
    localparam logic PORT_EN_RST    = 1'b1;

    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef enum logic [1:0] {
        PH_INSTR = 2'h0,
        PH_DATA  = 2'h1,
        PH_DONE  = 2'h3
    } dacpm_phase_t;

    typedef struct packed {
        dacpm_phase_t       phase;
        logic [2:0]         bitCnt;
        logic               rw;
        logic [4:0]         addr;
        logic [SHIFT_W-1:0] shift;
    } dacpm_frame_t;

    typedef struct packed {
        logic wrToggle;
        logic wrBit;
    } dacpm_persist_t;

    typedef struct packed {
        logic portEn;
        logic singleRate;
        logic threeWire;
        logic wrTogSeen;
        logic updPrev;
        logic updPulse;
        logic dclkPrev;
        logic clkOut;
        logic alarm;
    } dacpm_main_t;

endpackage

`default_nettype wire

// ===== verilog/dacpm_sync3.sv
`default_nettype none

module dacpm_sync3 #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst,
    // Data
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] agreed;
    } dacpm_sync_t;

    dacpm_sync_t st_q;
    dacpm_sync_t st_d;

    // ----------------------------------------
    // Three stages, output follows on agreement
    // ----------------------------------------
    always_comb begin
        st_d    = st_q;
        st_d.s1 = d;
        st_d.s2 = st_q.s1;
        st_d.s3 = st_q.s2;
        for (int i = 0; i < W; i++) begin
            if (st_q.s2[i] == st_q.s3[i]) begin
                st_d.agreed[i] = st_q.s3[i];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign q = st_q.agreed;

endmodule

`default_nettype wire

// ===== verilog/dacpm_buf2.sv
`default_nettype none

module dacpm_buf2 #(
    parameter int W = 16
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst,
    // Fill side
    input  wire logic         inValid,
    output logic              inReady,
    input  wire logic [W-1:0] inData,
    // Drain side
    output logic              outValid,
    input  wire logic         outReady,
    output logic      [W-1:0] outData
);

    typedef struct packed {
        logic [W-1:0] mem0;
        logic [W-1:0] mem1;
        logic [1:0]   cnt;
    } dacpm_buf_t;

    dacpm_buf_t st_q;
    dacpm_buf_t st_d;
    logic       push;
    logic       pop;

    assign inReady  = (st_q.cnt != 2'h2);
    assign outValid = (st_q.cnt != 2'h0);
    assign outData  = st_q.mem0;
    assign push     = inValid & inReady;
    assign pop      = outValid & outReady;

    // ----------------------------------------
    // Head entry is always mem0
    // ----------------------------------------
    always_comb begin
        st_d = st_q;
        case ({push, pop})
            2'h2: begin
                if (st_q.cnt == 2'h0) begin
                    st_d.mem0 = inData;
                end else begin
                    st_d.mem1 = inData;
                end
                st_d.cnt = st_q.cnt + 2'h1;
            end
            2'h1: begin
                st_d.mem0 = st_q.mem1;
                st_d.cnt  = st_q.cnt - 2'h1;
            end
            2'h3: begin
                st_d.mem0 = inData;
            end
            default: begin
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    a_buf_hold: assert property (@(posedge clk) disable iff (rst)
        outValid && !outReady |=> outValid && $stable(outData))
        else $error("Buffer head changed while stalled");

    a_buf_count: assert property (@(posedge clk) disable iff (rst)
        push && !pop |=> st_q.cnt == $past(st_q.cnt) + 2'h1)
        else $error("Buffer count did not follow a push");

endmodule

`default_nettype wire

// ===== verilog/dacpm_pin_mux.sv
// Summary of operation
// - Four-wire mode drives the serial output pin; three-wire mode floats it.
// - Four-wire mode never drives the serial data pin; it only receives.
// - Three-wire mode drives read data on the data pin; host releases it.
// - Port disabled by strap: serial output pin reports the alarm condition.
// - Port disabled by strap: serial clock pin acts as update input.
// - High disable strap turns the serial port off; low keeps it on.
// - With port disabled, high single-rate strap selects single data rate.
// - Chip select is active low; transfers only count while it is low.
// - Sixteen true and complement data bits plus clock in and out pairs.
// - Bit 7 of address 0x00 picks three-wire (1) or four-wire (0).
`default_nettype none

module dacpm_pin_mux (
    // Clock and reset
    input  wire logic                         mclk,
    input  wire logic                         srst,
    // Strap pins
    input  wire logic                         serialPortDisableStrap,
    input  wire logic                         singleRateStrap,
    // Serial port pins
    input  wire logic                         sclk,
    input  wire logic                         csN,
    input  wire logic                         sdioIn,
    output logic                              sdioOut,
    output logic                              sdioOeN,
    output logic                              sdoOut,
    output logic                              sdoOeN,
    // Data interface pins
    input  wire logic [dacpm_pkg::BUS_W-1:0] inputDataBusP,
    input  wire logic [dacpm_pkg::BUS_W-1:0] inputDataBusN,
    input  wire logic                         dataClockInP,
    input  wire logic                         dataClockInN,
    output logic                              dataClockOutP,
    output logic                              dataClockOutN,
    // Word stream to the converter core
    output logic                              wordValid,
    input  wire logic                         wordReady,
    output logic      [dacpm_pkg::BUS_W-1:0] wordData,
    // Synchronizer and mode side
    input  wire logic                         syncAlarmCond,
    output logic                              syncUpdatePulse,
    output logic                              portEnabled,
    output logic                              singleRate,
    output logic                              threeWireSelect
);

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    dacpm_pkg::dacpm_frame_t   fr_q;
    dacpm_pkg::dacpm_frame_t   fr_d;
    dacpm_pkg::dacpm_persist_t ps_q;
    dacpm_pkg::dacpm_persist_t ps_d;
    dacpm_pkg::dacpm_main_t    mn_q;
    dacpm_pkg::dacpm_main_t    mn_d;

    logic [dacpm_pkg::SYNC_W-1:0]  syncIn;
    logic [dacpm_pkg::SYNC_W-1:0]  syncOut;
    logic                          sDis;
    logic                          sSdr;
    logic                          sSclk;
    logic                          sTog;
    logic                          sDclkP;
    logic                          sDclkN;
    logic [dacpm_pkg::BUS_W-1:0]   sBusP;
    logic [dacpm_pkg::BUS_W-1:0]   sBusN;
    logic [dacpm_pkg::SHIFT_W-1:0] instrWord;
    logic                          wrFire;
    logic                          readDrive;
    logic                          capture;
    logic                          bufInReady;

    // ----------------------------------------
    // Read value of the serial register space
    // ----------------------------------------
    function automatic logic [dacpm_pkg::SHIFT_W-1:0] readValue(
        input logic [4:0] addr,
        input logic       modeBit
    );
        logic [dacpm_pkg::SHIFT_W-1:0] v;
        v = dacpm_pkg::READ_ZERO;
        if (addr == dacpm_pkg::MODE_ADDR) begin
            v[dacpm_pkg::MODE_BIT] = modeBit;
        end
        return v;
    endfunction

    // ----------------------------------------
    // Serial frame on the link clock
    // ----------------------------------------
    assign instrWord = {fr_q.shift[dacpm_pkg::SHIFT_W-2:0], sdioIn};

    always_comb begin
        fr_d   = fr_q;
        wrFire = 1'b0;
        unique case (fr_q.phase)
            dacpm_pkg::PH_INSTR: begin
                fr_d.shift  = instrWord;
                fr_d.bitCnt = fr_q.bitCnt + 3'h1;
                if (fr_q.bitCnt == dacpm_pkg::LAST_BIT) begin
                    fr_d.rw    = instrWord[dacpm_pkg::RW_BIT];
                    fr_d.addr  = instrWord[4:0];
                    fr_d.phase = dacpm_pkg::PH_DATA;
                    if (instrWord[dacpm_pkg::RW_BIT] == dacpm_pkg::CMD_READ) begin
                        fr_d.shift = readValue(instrWord[4:0], ps_q.wrBit);
                    end
                end
            end
            dacpm_pkg::PH_DATA: begin
                fr_d.bitCnt = fr_q.bitCnt + 3'h1;
                if (fr_q.rw == dacpm_pkg::CMD_READ) begin
                    fr_d.shift = {fr_q.shift[dacpm_pkg::SHIFT_W-2:0], 1'b0};
                end else begin
                    fr_d.shift = instrWord;
                end
                if (fr_q.bitCnt == dacpm_pkg::LAST_BIT) begin
                    fr_d.phase = dacpm_pkg::PH_DONE;
                    wrFire = (fr_q.rw != dacpm_pkg::CMD_READ)
                           && (fr_q.addr == dacpm_pkg::MODE_ADDR);
                end
            end
            dacpm_pkg::PH_DONE: begin
                fr_d = fr_q;
            end
        endcase
    end

    // frame held in reset while deselected
    always_ff @(posedge sclk or posedge csN) begin
        if (csN) begin
            fr_q <= '0;
        end else begin
            fr_q <= fr_d;
        end
    end

    always_comb begin
        ps_d = ps_q;
        if (wrFire) begin
            ps_d.wrToggle = ~ps_q.wrToggle;
            ps_d.wrBit    = instrWord[dacpm_pkg::MODE_BIT];
        end
    end

    always_ff @(posedge sclk or posedge srst) begin
        if (srst) begin
            ps_q <= '0;
        end else begin
            ps_q <= ps_d;
        end
    end

    // ----------------------------------------
    // Pin and link crossings into mclk
    // ----------------------------------------
    assign syncIn = {serialPortDisableStrap, singleRateStrap, sclk, ps_q.wrToggle,
                     dataClockInP, dataClockInN, inputDataBusP, inputDataBusN};

    dacpm_sync3 #(
        .W (dacpm_pkg::SYNC_W)
    ) u_sync (
        .clk (mclk),
        .rst (srst),
        .d   (syncIn),
        .q   (syncOut)
    );

    assign {sDis, sSdr, sSclk, sTog, sDclkP, sDclkN, sBusP, sBusN} = syncOut;

    // ----------------------------------------
    // Mode, update and data control on mclk
    // ----------------------------------------
    // pair check on clock and every bit
    assign capture = (sDclkP ^ sDclkN) && (sDclkP != mn_q.dclkPrev)
                   && (!mn_q.singleRate || sDclkP) && (sBusP == ~sBusN);

    always_comb begin
        mn_d = mn_q;
        mn_d.portEn     = ~sDis;
        mn_d.singleRate = sDis & sSdr;
        mn_d.alarm      = syncAlarmCond;
        mn_d.updPrev    = sSclk;
        mn_d.updPulse   = ~mn_q.portEn & sSclk & ~mn_q.updPrev;
        mn_d.wrTogSeen  = sTog;
        // apply mode bit from a write
        if ((sTog != mn_q.wrTogSeen) && mn_q.portEn) begin
            mn_d.threeWire = ps_q.wrBit;
        end
        mn_d.dclkPrev = sDclkP;
        mn_d.clkOut   = bufInReady ? ~mn_q.clkOut : mn_q.clkOut;
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            mn_q           <= '0;
            mn_q.portEn    <= dacpm_pkg::PORT_EN_RST;
            mn_q.threeWire <= dacpm_pkg::THREE_WIRE_RST;
        end else begin
            mn_q <= mn_d;
        end
    end

    dacpm_buf2 #(
        .W (dacpm_pkg::BUS_W)
    ) u_buf (
        .clk      (mclk),
        .rst      (srst),
        .inValid  (capture),
        .inReady  (bufInReady),
        .inData   (sBusP),
        .outValid (wordValid),
        .outReady (wordReady),
        .outData  (wordData)
    );

    // ----------------------------------------
    // Pin function selection
    // ----------------------------------------
    assign readDrive = mn_q.portEn && !csN && (fr_q.phase == dacpm_pkg::PH_DATA)
                     && (fr_q.rw == dacpm_pkg::CMD_READ);

    // output pin floated only in three-wire with port enabled
    // alarm on output pin when disabled
    assign sdoOut  = mn_q.portEn ? fr_q.shift[dacpm_pkg::SHIFT_W-1] : mn_q.alarm;
    assign sdoOeN  = mn_q.portEn & mn_q.threeWire;

    // data pin never driven in four-wire
    assign sdioOut = fr_q.shift[dacpm_pkg::SHIFT_W-1];
    assign sdioOeN = ~(readDrive & mn_q.threeWire);

    assign dataClockOutP   = mn_q.clkOut;
    assign dataClockOutN   = ~mn_q.clkOut;
    assign syncUpdatePulse = mn_q.updPulse;
    assign portEnabled     = mn_q.portEn;
    assign singleRate      = mn_q.singleRate;
    assign threeWireSelect = mn_q.threeWire;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    a_sdo_float_3w: assert property (@(posedge mclk) disable iff (srst)
        portEnabled && threeWireSelect |-> sdoOeN)
        else $error("Serial output driven in three-wire mode");

    a_sdo_drive_4w: assert property (@(posedge mclk) disable iff (srst)
        portEnabled && !threeWireSelect |-> !sdoOeN)
        else $error("Serial output not driven in four-wire mode");

    a_sdio_input_4w: assert property (@(posedge mclk) disable iff (srst)
        !threeWireSelect |-> sdioOeN)
        else $error("Data pin driven in four-wire mode");

    a_sdio_read_cs: assert property (@(posedge sclk) disable iff (srst)
        !sdioOeN |-> !csN && fr_q.rw && threeWireSelect)
        else $error("Data pin driven outside a selected read");

    a_alarm_route: assert property (@(posedge mclk) disable iff (srst)
        !portEnabled && $past(!srst) |-> sdoOut == $past(syncAlarmCond) && !sdoOeN)
        else $error("Alarm not routed to output pin");

    a_update_pulse: assert property (@(posedge mclk) disable iff (srst)
        syncUpdatePulse |-> !$past(portEnabled) ##1 !syncUpdatePulse)
        else $error("Update pulse while port enabled or too long");

    a_strap_disable: assert property (@(posedge mclk) disable iff (srst)
        serialPortDisableStrap [*6] |-> !portEnabled)
        else $error("Port still enabled with disable strap high");

    a_single_rate: assert property (@(posedge mclk) disable iff (srst)
        singleRate |-> !portEnabled)
        else $error("Single rate selected while port enabled");

    a_cs_frame: assert property (@(posedge sclk) disable iff (srst)
        fr_q.phase != dacpm_pkg::PH_INSTR |-> !csN)
        else $error("Frame active while deselected");

    a_pair_word: assert property (@(posedge mclk) disable iff (srst)
        capture && bufInReady |=> wordValid)
        else $error("Paired word not offered to the core");

    a_mode_gate: assert property (@(posedge mclk) disable iff (srst)
        $changed(threeWireSelect) |-> $past(portEnabled) && $past(sTog != mn_q.wrTogSeen))
        else $error("Mode changed without an enabled write");

endmodule

`default_nettype wire

// ===== verification/dacpm_data_pump.sv
`default_nettype none

module dacpm_data_pump (
    // Data pins
    output var logic [dacpm_pkg::BUS_W-1:0] busP,
    output var logic [dacpm_pkg::BUS_W-1:0] busN,
    // Data clock pins
    output var logic                        clkP,
    output var logic                        clkN
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        busP = 16'h0000;
        busN = 16'hffff;
        clkP = 1'b0;
        clkN = 1'b1;
    end

    // ----------------------------------------
    // One word per data clock edge
    // ----------------------------------------
    // true and complement pairs
    task automatic send(input logic [15:0] w, input logic brk, input int holdNs);
        busP = w;
        busN = brk ? {~w[15:1], w[0]} : ~w;
        #(holdNs);
        clkP = ~clkP;
        clkN = ~clkP;
        #(holdNs);
    endtask
endmodule

`default_nettype wire

// ===== verification/test_dacpm_pin_mux.sv
`default_nettype none

module test_dacpm_pin_mux;
    timeunit 1ns;
    timeprecision 100ps;

    logic        mclk;
    logic        srst;
    logic        serialPortDisableStrap;
    logic        singleRateStrap;
    logic        sclk;
    logic        csN;
    logic        sdioIn;
    logic        sdioOut;
    logic        sdioOeN;
    logic        sdoOut;
    logic        sdoOeN;
    logic [15:0] inputDataBusP;
    logic [15:0] inputDataBusN;
    logic        dataClockInP;
    logic        dataClockInN;
    logic        dataClockOutP;
    logic        dataClockOutN;
    logic        wordValid;
    logic        wordReady;
    logic [15:0] wordData;
    logic        syncAlarmCond;
    logic        syncUpdatePulse;
    logic        portEnabled;
    logic        singleRate;
    logic        threeWireSelect;
    logic [7:0]  rd;
    logic        oe;
    logic        c;
    logic [15:0] w;
    int          n;
    int          num_errors;
    int          compares;

    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    dacpm_pin_mux u_dut (
        .mclk(mclk), .srst(srst), .serialPortDisableStrap(serialPortDisableStrap),
        .singleRateStrap(singleRateStrap), .sclk(sclk), .csN(csN), .sdioIn(sdioIn),
        .sdioOut(sdioOut), .sdioOeN(sdioOeN), .sdoOut(sdoOut), .sdoOeN(sdoOeN),
        .inputDataBusP(inputDataBusP), .inputDataBusN(inputDataBusN),
        .dataClockInP(dataClockInP), .dataClockInN(dataClockInN),
        .dataClockOutP(dataClockOutP), .dataClockOutN(dataClockOutN),
        .wordValid(wordValid), .wordReady(wordReady), .wordData(wordData),
        .syncAlarmCond(syncAlarmCond), .syncUpdatePulse(syncUpdatePulse),
        .portEnabled(portEnabled), .singleRate(singleRate),
        .threeWireSelect(threeWireSelect)
    );

    dacpm_data_pump u_pump (
        .busP(inputDataBusP), .busN(inputDataBusN), .clkP(dataClockInP), .clkN(dataClockInN)
    );

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic end_of_test();
        $display("Mismatches %0d, compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic cyc(input int k);
        repeat (k) @(negedge mclk);
    endtask

    // Serial frame; link clock runs only while the frame lasts
    task automatic xfer(input logic [15:0] f, input logic sel, input logic tw);
        csN = ~sel;
        oe = 1'b1;
        #40;
        for (int i = 15; i >= 0; i--) begin
            // host toggles the data pin during read data bits
            sdioIn = (i < 8 && f[15]) ? ~sdioIn : f[i];
            #40 sclk = 1'b1;
            #40 sclk = 1'b0;
            if (i > 0 && i < 9) begin
                rd[i-1] = tw ? sdioOut : sdoOut;
                oe = oe & sdioOeN;
            end
        end
        #40 csN = 1'b1;
        cyc(10);
    endtask

    task automatic pop(output logic [15:0] v);
        int k;
        k = 0;
        while (wordValid !== 1'b1 && k < 40) begin
            cyc(1);
            k++;
        end
        if (wordValid !== 1'b1) begin
            num_errors++;
            end_of_test();
        end else begin
            v = wordData;
            wordReady = 1'b1;
            cyc(1);
            wordReady = 1'b0;
            cyc(1);
        end
    endtask

    initial begin
        #200000;
        num_errors++;
        end_of_test();
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        srst = 1'b1;
        serialPortDisableStrap = 1'b0;
        singleRateStrap = 1'b0;
        sclk = 1'b0;
        csN = 1'b1;
        sdioIn = 1'b0;
        wordReady = 1'b0;
        syncAlarmCond = 1'b0;
        num_errors = 0;
        compares = 0;
        cyc(2);
        // One link edge in reset; csN and srst already hold the frame and the mode shadow clear
        sclk = 1'b1;
        cyc(1);
        sclk = 1'b0;
        cyc(3);
        chk("portEnabled rst", portEnabled, 16'h1);
        chk("sdoOeN rst", sdoOeN, 16'h0);
        chk("sdioOeN rst", sdioOeN, 16'h1);
        chk("wordValid rst", wordValid, 16'h0);
        srst = 1'b0;
        cyc(10);
        xfer(16'h8000, 1'b1, 1'b0);
        chk("read 4w", rd, 16'h00);
        chk("sdio never driven", oe, 16'h1);
        xfer(16'h0080, 1'b1, 1'b0);
        chk("threeWireSelect", threeWireSelect, 16'h1);
        chk("sdoOeN 3w", sdoOeN, 16'h1);
        xfer(16'h8000, 1'b1, 1'b1);
        chk("read 3w", rd, 16'h80);
        chk("sdio driven", oe, 16'h0);
        chk("sdio released", sdioOeN, 16'h1);
        xfer(16'h8100, 1'b1, 1'b1);
        chk("read other addr", rd, 16'h00);
        xfer(16'h0000, 1'b0, 1'b1);
        chk("deselected write", threeWireSelect, 16'h1);
        xfer(16'h0000, 1'b1, 1'b1);
        chk("back to 4w", threeWireSelect, 16'h0);
        chk("sdoOeN 4w", sdoOeN, 16'h0);
        c = dataClockOutP;
        cyc(1);
        chk("clock out runs", dataClockOutP, {~c});
        u_pump.send(16'h1234, 1'b0, 250);
        u_pump.send(16'habcd, 1'b1, 250);
        u_pump.send(16'h5a5a, 1'b0, 250);
        cyc(2);
        c = dataClockOutP;
        cyc(3);
        chk("clock out stops", dataClockOutP, c);
        chk("clock out pair", dataClockOutN, {~dataClockOutP});
        pop(w);
        chk("word 1", w, 16'h1234);
        pop(w);
        chk("word 2", w, 16'h5a5a);
        cyc(10);
        chk("broken pair dropped", wordValid, 16'h0);
        serialPortDisableStrap = 1'b1;
        singleRateStrap = 1'b1;
        cyc(8);
        chk("port off", portEnabled, 16'h0);
        chk("single rate", singleRate, 16'h1);
        chk("alarm pin driven", sdoOeN, 16'h0);
        for (int k = 0; k < 2; k++) begin
            syncAlarmCond = ~k[0];
            cyc(3);
            chk("alarm out", sdoOut, {~k[0]});
        end
        n = 0;
        sclk = 1'b1;
        repeat (12) begin
            cyc(1);
            if (syncUpdatePulse === 1'b1) n++;
        end
        sclk = 1'b0;
        chk("update pulses", n[15:0], 16'h1);
        u_pump.send(16'h0f0f, 1'b0, 250);
        u_pump.send(16'hf0f0, 1'b0, 250);
        cyc(2);
        pop(w);
        chk("sdr word", w, 16'hf0f0);
        cyc(10);
        chk("sdr falling ignored", wordValid, 16'h0);
        end_of_test();
    end
endmodule

`default_nettype wire
